// >>> qsg_status_top.v
// Purpose: Error rate and calibration questionable status groups behind APB.
// Assumes: Status inputs are asynchronous pins; 200 MHz sys_clk.
// Notes:   Reads answer with zero wait states; unmapped reads return zero.
//          Event words clear on the setup edge of their own read.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`include "qsg_defs.vh"
`default_nettype none
module qsg_status_top #(
  parameter [31:0] NOCLK_CYC = `QSG_NOCLK_CYC
) (
  input  wire        sys_clk,
  input  wire        resetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        berActive,
  input  wire        berClkPin,
  input  wire        calZeroFail,
  input  wire [14:0] berCondExtra,
  input  wire [14:0] calCondExtra,
  output reg         quesBerSum,
  output reg         quesCalSum,
  output reg         irq
);
  localparam W = `QSG_GRP_W;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  // Every pin passes two flops; only the second flop of each pair is read.
  // The extra pins are not gray coded, so one word may land a cycle skewed.
  reg         actA_ff;
  reg         actB_ff;
  reg         clkA_ff;
  reg         clkB_ff;
  reg         failA_ff;
  reg         failB_ff;
  reg  [14:0] berXA_ff;
  reg  [14:0] berXB_ff;
  reg  [14:0] calXA_ff;
  reg  [14:0] calXB_ff;
  reg         clkPrev_ff;
  wire        sBerActive = actB_ff;
  wire        sBerClk    = clkB_ff;
  wire        sCalFail   = failB_ff;
  wire [14:0] sBerExtra  = berXB_ff;
  wire [14:0] sCalExtra  = calXB_ff;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      actA_ff    <= 1'b0;
      actB_ff    <= 1'b0;
      clkA_ff    <= 1'b0;
      clkB_ff    <= 1'b0;
      failA_ff   <= 1'b0;
      failB_ff   <= 1'b0;
      berXA_ff   <= 15'h0000;
      berXB_ff   <= 15'h0000;
      calXA_ff   <= 15'h0000;
      calXB_ff   <= 15'h0000;
      clkPrev_ff <= 1'b0;
    end else begin
      actA_ff    <= berActive;
      actB_ff    <= actA_ff;
      clkA_ff    <= berClkPin;
      clkB_ff    <= clkA_ff;
      failA_ff   <= calZeroFail;
      failB_ff   <= failA_ff;
      berXA_ff   <= berCondExtra;
      berXB_ff   <= berXA_ff;
      calXA_ff   <= calCondExtra;
      calXB_ff   <= calXA_ff;
      clkPrev_ff <= sBerClk;
    end
  end

  // ---------------------------------------------------------------
  // Missing measurement clock watchdog
  // ---------------------------------------------------------------
  // The timer only runs during a measurement so an idle link never flags.
  // A 32-bit count limits the timeout to about 21 seconds at 200 MHz.
  reg  [31:0] noClkCnt_ff;
  reg         noClk_ff;
  wire        clkEdge = sBerClk & ~clkPrev_ff;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      noClkCnt_ff <= 32'h0000_0000;
      noClk_ff    <= 1'b0;
    end else if (!sBerActive || clkEdge) begin
      noClkCnt_ff <= 32'h0000_0000;
      noClk_ff    <= 1'b0;
    end else if (noClkCnt_ff < NOCLK_CYC) begin
      noClkCnt_ff <= noClkCnt_ff + 32'h0000_0001;
    end else begin
      noClk_ff    <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Live condition words
  // ---------------------------------------------------------------
  // Nothing holds these words, so a read shows the present pin state.
  wire [W-1:0] berCond = {sBerExtra, noClk_ff};
  wire [W-1:0] calCond = {sCalExtra, sCalFail};

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  reg  [W-1:0] berEn_ff;
  reg  [W-1:0] berPtr_ff;
  reg  [W-1:0] berNtr_ff;
  reg  [W-1:0] calEn_ff;
  reg  [W-1:0] calPtr_ff;
  reg  [W-1:0] calNtr_ff;
  reg  [31:0]  queueEn_ff;
  reg  [1:0]   irqStat_ff;
  reg  [1:0]   irqMask_ff;
  reg          pready_ff;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  wire apbAcc   = psel & penable;
  wire wrAcc    = apbAcc & pwrite;
  wire rdSet    = psel & ~penable & ~pwrite;
  wire doPreset = wrAcc && (paddr == `QSG_PRESET);
  wire wrBerEn  = wrAcc && (paddr == `QSG_BER_ENABLE);
  wire wrBerPtr = wrAcc && (paddr == `QSG_BER_PTR);
  wire wrBerNtr = wrAcc && (paddr == `QSG_BER_NTR);
  wire wrCalEn  = wrAcc && (paddr == `QSG_CAL_ENABLE);
  wire wrCalPtr = wrAcc && (paddr == `QSG_CAL_PTR);
  wire wrCalNtr = wrAcc && (paddr == `QSG_CAL_NTR);
  wire wrQueEn  = wrAcc && (paddr == `QSG_QUEUE_EN);
  wire wrIrqMsk = wrAcc && (paddr == `QSG_IRQ_MASK);
  // The event word is cleared on the same edge that loads prdata, so an
  // edge seen in the setup cycle stays latched for the next read.
  wire berEvRd  = rdSet && (paddr == `QSG_BER_EVENT);
  wire calEvRd  = rdSet && (paddr == `QSG_CAL_EVENT);

  // Ready comes from a flop so the bus sees no combinational path; it is
  // low during reset and until the first edge after release. Errors are never signalled.
  assign pready  = pready_ff;
  assign pslverr = 1'b0;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pready_ff <= 1'b0;
    end else begin
      pready_ff <= 1'b1;
    end
  end

  wire [W-1:0] berEvent;
  wire [W-1:0] calEvent;
  wire         berSum;
  wire         calSum;
  wire         berNew;
  wire         calNew;

  // ---------------------------------------------------------------
  // Group instances
  // ---------------------------------------------------------------
  // Both groups are the same logic; only their inputs differ.
  qsg_group #(.W(W)) uBer (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .condIn   (berCond),
    .ptrMask  (berPtr_ff),
    .ntrMask  (berNtr_ff),
    .enMask   (berEn_ff),
    .eventRd  (berEvRd),
    .eventVal (berEvent),
    .summary  (berSum),
    .newEvent (berNew)
  );

  qsg_group #(.W(W)) uCal (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .condIn   (calCond),
    .ptrMask  (calPtr_ff),
    .ntrMask  (calNtr_ff),
    .enMask   (calEn_ff),
    .eventRd  (calEvRd),
    .eventVal (calEvent),
    .summary  (calSum),
    .newEvent (calNew)
  );

  // ---------------------------------------------------------------
  // Filter and enable registers
  // ---------------------------------------------------------------
  // Masks take the written word as plain binary weights. A preset outranks
  // a plain write, and the interrupt mask is left alone by a preset.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      berEn_ff <= `QSG_EN_RST;
    end else if (doPreset) begin
      berEn_ff <= `QSG_EN_RST;
    end else if (wrBerEn) begin
      berEn_ff <= pwdata[W-1:0];
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      berPtr_ff <= `QSG_PTR_RST;
    end else if (doPreset) begin
      berPtr_ff <= `QSG_PTR_RST;
    end else if (wrBerPtr) begin
      berPtr_ff <= pwdata[W-1:0];
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      berNtr_ff <= `QSG_NTR_RST;
    end else if (doPreset) begin
      berNtr_ff <= `QSG_NTR_RST;
    end else if (wrBerNtr) begin
      berNtr_ff <= pwdata[W-1:0];
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      calEn_ff <= `QSG_EN_RST;
    end else if (doPreset) begin
      calEn_ff <= `QSG_EN_RST;
    end else if (wrCalEn) begin
      calEn_ff <= pwdata[W-1:0];
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      calPtr_ff <= `QSG_PTR_RST;
    end else if (doPreset) begin
      calPtr_ff <= `QSG_PTR_RST;
    end else if (wrCalPtr) begin
      calPtr_ff <= pwdata[W-1:0];
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      calNtr_ff <= `QSG_NTR_RST;
    end else if (doPreset) begin
      calNtr_ff <= `QSG_NTR_RST;
    end else if (wrCalNtr) begin
      calNtr_ff <= pwdata[W-1:0];
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      queueEn_ff <= `QSG_QEN_RST;
    end else if (doPreset) begin
      queueEn_ff <= `QSG_QEN_RST;
    end else if (wrQueEn) begin
      queueEn_ff <= pwdata;
    end
  end

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irqMask_ff <= 2'h0;
    end else if (wrIrqMsk) begin
      irqMask_ff <= pwdata[1:0];
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status: write one to clear, a new event wins
  // ---------------------------------------------------------------
  // Each bit records that its group latched a new event since the last clear.
  wire       statClr = wrAcc && (paddr == `QSG_IRQ_STAT);
  wire [1:0] clrBits = statClr ? pwdata[1:0] : 2'h0;
  wire [1:0] nxt_irqStat = (irqStat_ff & ~clrBits) | {calNew, berNew};

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irqStat_ff <= 2'h0;
      irq        <= 1'b0;
    end else begin
      irqStat_ff <= nxt_irqStat;
      irq        <= |(nxt_irqStat & irqMask_ff);
    end
  end

  // ---------------------------------------------------------------
  // Summary outputs
  // ---------------------------------------------------------------
  // The pins are registered copies, loaded on the same edge that loads the read data.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      quesBerSum <= 1'b0;
      quesCalSum <= 1'b0;
    end else begin
      quesBerSum <= berSum;
      quesCalSum <= calSum;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  reg  [31:0] rdMux;
  wire [31:0] quesCond = ({31'h0000_0000, berSum} << `QSG_BER_SUM_BIT)
                       | ({31'h0000_0000, calSum} << `QSG_CAL_SUM_BIT);

  // Each value reads zero-extended in the low bits, except the summary word, which uses bits 12 and 8.
  // Group words occupy bits 15:0; the upper half reads zero except for the queue enable word.
  always @* begin
    case (paddr)
      `QSG_BER_COND:   rdMux = {16'h0000, berCond};
      `QSG_BER_EVENT:  rdMux = {16'h0000, berEvent};
      `QSG_BER_ENABLE: rdMux = {16'h0000, berEn_ff};
      `QSG_BER_PTR:    rdMux = {16'h0000, berPtr_ff};
      `QSG_BER_NTR:    rdMux = {16'h0000, berNtr_ff};
      `QSG_CAL_COND:   rdMux = {16'h0000, calCond};
      `QSG_CAL_EVENT:  rdMux = {16'h0000, calEvent};
      `QSG_CAL_ENABLE: rdMux = {16'h0000, calEn_ff};
      `QSG_CAL_PTR:    rdMux = {16'h0000, calPtr_ff};
      `QSG_CAL_NTR:    rdMux = {16'h0000, calNtr_ff};
      `QSG_QUES_COND:  rdMux = quesCond;
      `QSG_QUEUE_EN:   rdMux = queueEn_ff;
      `QSG_IRQ_STAT:   rdMux = {30'h0000_0000, irqStat_ff};
      `QSG_IRQ_MASK:   rdMux = {30'h0000_0000, irqMask_ff};
      default:         rdMux = 32'h0000_0000;
    endcase
  end

  // Read data is registered at the setup cycle so it is stable in access.
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h0000_0000;
    end else if (rdSet) begin
      prdata <= rdMux;
    end
  end
endmodule
`default_nettype wire

// >>> qsg_defs.vh
// Purpose: Constants for the questionable status groups block.
// Assumes: APB slave, 32-bit data, one aligned word per register.
// Notes:   Offsets are byte addresses.
`ifndef QSG_DEFS_VH
`define QSG_DEFS_VH

`define QSG_GRP_W        16
`define QSG_BER_COND     12'h000
`define QSG_BER_EVENT    12'h004
`define QSG_BER_ENABLE   12'h008
`define QSG_BER_PTR      12'h00C
`define QSG_BER_NTR      12'h010
`define QSG_CAL_COND     12'h014
`define QSG_CAL_EVENT    12'h018
`define QSG_CAL_ENABLE   12'h01C
`define QSG_CAL_PTR      12'h020
`define QSG_CAL_NTR      12'h024
`define QSG_QUES_COND    12'h028
`define QSG_QUEUE_EN     12'h02C
`define QSG_PRESET       12'h030
`define QSG_IRQ_STAT     12'h034
`define QSG_IRQ_MASK     12'h038
`define QSG_BER_SUM_BIT  12
`define QSG_CAL_SUM_BIT  8
`define QSG_PTR_RST      16'hFFFF
`define QSG_NTR_RST      16'h0000
`define QSG_EN_RST       16'h0000
`define QSG_QEN_RST      32'h0000_0000
`define QSG_CLK_HZ       200000000
`define QSG_NOCLK_S      3
`define QSG_NOCLK_CYC    (`QSG_CLK_HZ * `QSG_NOCLK_S)

`endif

// >>> qsg_group.v
// Purpose: One status group: condition, transition filters, event latch, summary.
// Assumes: Condition input already synchronous to sys_clk.
// Notes:   Set wins over clear-on-read in the same cycle.
`default_nettype none
module qsg_group #(
  parameter W = 16
) (
  input  wire         sys_clk,
  input  wire         resetn,
  input  wire [W-1:0] condIn,
  input  wire [W-1:0] ptrMask,
  input  wire [W-1:0] ntrMask,
  input  wire [W-1:0] enMask,
  input  wire         eventRd,
  output wire [W-1:0] eventVal,
  output wire         summary,
  output wire         newEvent
);
  reg  [W-1:0] condPrev_ff;
  reg  [W-1:0] event_ff;
  wire [W-1:0] hits;
  wire [W-1:0] nxt_event;

  // An event needs an edge and the filter for that direction.
  assign hits = (condIn & ~condPrev_ff & ptrMask)
              | (~condIn & condPrev_ff & ntrMask);
  assign nxt_event = (eventRd ? {W{1'b0}} : event_ff) | hits;
  assign eventVal  = event_ff;
  assign summary   = |(event_ff & enMask);
  assign newEvent  = |hits;

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      condPrev_ff <= {W{1'b0}};
      event_ff    <= {W{1'b0}};
    end else begin
      condPrev_ff <= condIn;
      event_ff    <= nxt_event;
    end
  end
endmodule
`default_nettype wire

// >>> qsg_status_asserts.sv
// Purpose: Port-level assertions for the status groups block.
// Assumes: Bound to qsg_status_top; APB read data loads at setup.
// Notes:   A condition read is judged against the pins three edges earlier.
`include "qsg_defs.vh"
`default_nettype none
module qsg_status_asserts #(
  parameter [31:0] NOCLK_CYC = `QSG_NOCLK_CYC
) (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        berActive,
  input wire logic        berClkPin,
  input wire logic        calZeroFail,
  input wire logic [14:0] berCondExtra,
  input wire logic [14:0] calCondExtra,
  input wire logic        quesBerSum,
  input wire logic        quesCalSum,
  input wire logic        irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  wire         rdSet = psel && !penable && !pwrite;
  wire         berHit = psel && penable && (paddr == `QSG_BER_EVENT
                 || paddr == `QSG_BER_ENABLE || paddr == `QSG_PRESET);
  logic [2:0]  berHist_ff;
  logic [31:0] idleCnt_ff;
  logic        prevClk_ff;
  // The summary may only drop after a read, enable write or preset touched it.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      berHist_ff <= 3'h0;
      idleCnt_ff <= 32'h0000_0000;
      prevClk_ff <= 1'b0;
    end else begin
      berHist_ff <= {berHist_ff[1:0], berHit};
      prevClk_ff <= berClkPin;
      idleCnt_ff <= (!berActive || (berClkPin && !prevClk_ff)) ? 32'h0000_0000
                    : idleCnt_ff + 32'h0000_0001;
    end
  end
  cond_follow_a: assert property (rdSet && paddr == `QSG_BER_COND
    |=> prdata[15:1] == $past(berCondExtra, 3))
    else $error("condition read differs from pins");
  cal_cond_a: assert property (rdSet && paddr == `QSG_CAL_COND
    |=> prdata[15:0] == {$past(calCondExtra, 3), $past(calZeroFail, 3)})
    else $error("calibration condition wrong");
  noclk_set_a: assert property (rdSet && paddr == `QSG_BER_COND
    && idleCnt_ff > NOCLK_CYC + 6 |=> prdata[0]) else $error("missing clock not flagged");
  unmapped_zero_a: assert property (rdSet && paddr > `QSG_IRQ_MASK
    |=> prdata == 32'h0000_0000) else $error("unmapped read not zero");
  upper_zero_a: assert property (rdSet && paddr <= `QSG_CAL_NTR
    |=> prdata[31:16] == 16'h0000) else $error("upper bits not zero");
  ber_sum_a: assert property (rdSet && paddr == `QSG_QUES_COND
    |=> prdata[`QSG_BER_SUM_BIT] == quesBerSum) else $error("error rate summary mismatch");
  cal_sum_a: assert property (rdSet && paddr == `QSG_QUES_COND
    |=> prdata[`QSG_CAL_SUM_BIT] == quesCalSum) else $error("calibration summary mismatch");
  sum_fall_a: assert property ($fell(quesBerSum) |-> berHist_ff != 3'h0)
    else $error("summary dropped without cause");
  cover property (rdSet && paddr == `QSG_BER_EVENT);
  cover property ($rose(quesBerSum));
  cover property ($rose(irq));
endmodule
bind qsg_status_top qsg_status_asserts #(.NOCLK_CYC(NOCLK_CYC)) qsg_status_asserts_i (
  .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .berActive(berActive), .berClkPin(berClkPin),
  .calZeroFail(calZeroFail), .berCondExtra(berCondExtra), .calCondExtra(calCondExtra),
  .quesBerSum(quesBerSum), .quesCalSum(quesCalSum), .irq(irq));
`default_nettype wire

// >>> qsg_tb.sv
// Purpose: Self-checking bench for the status groups block.
// Assumes: Pipeline latencies of a few cycles from pin to output.
// Notes:   A short missing-clock count keeps the run brief.
`include "qsg_defs.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready, pslverr, quesBerSum, quesCalSum, irq;
  logic        berActive = 1'b0, berClkPin = 1'b0, calZeroFail = 1'b0;
  logic [14:0] berCondExtra = 15'h0000, calCondExtra = 15'h0000;
  int          fails = 0, checked = 0, cyc = 0;
  always #2.5 sys_clk = ~sys_clk;
  qsg_status_top #(.NOCLK_CYC(32'h0000_0014)) qsg_status_top_i (.sys_clk(sys_clk),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .berActive(berActive), .berClkPin(berClkPin), .calZeroFail(calZeroFail),
    .berCondExtra(berCondExtra), .calCondExtra(calCondExtra), .quesBerSum(quesBerSum),
    .quesCalSum(quesCalSum), .irq(irq));
  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] e, input string n);
    logic [31:0] q;
    apb(1'b0, a, 32'h0000_0000, q);
    chk(n, e, q);
  endtask
  task automatic setBer(input logic [14:0] v);
    @(posedge sys_clk);
    berCondExtra <= v;
    wt(6);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rc(`QSG_BER_PTR, 16'hFFFF, "berPtr");
    rc(`QSG_CAL_NTR, 16'h0000, "calNtr");
    rc(12'h040, 16'h0000, "unmapped");
    chk("pslverr", 32'h0000_0000, pslverr);
  endtask
  task automatic t_edges();
    setBer(15'h0001);
    rc(`QSG_BER_COND, 16'h0002, "berCond");
    rc(`QSG_BER_EVENT, 16'h0002, "berEvt");
    rc(`QSG_BER_EVENT, 16'h0000, "berEvt");
    setBer(15'h0000);
    rc(`QSG_BER_EVENT, 16'h0000, "berEvt");
    wr(`QSG_BER_PTR, 16'h0000);
    wr(`QSG_BER_NTR, 16'h0006);
    setBer(15'h0003);
    rc(`QSG_BER_EVENT, 16'h0000, "berEvt");
    setBer(15'h0000);
    rc(`QSG_BER_EVENT, 16'h0006, "berEvt");
  endtask
  task automatic t_sum();
    wr(`QSG_BER_PTR, 16'hFFFF);
    wr(`QSG_BER_ENABLE, 16'h0004);
    setBer(15'h0001);
    chk("berSum", 1'h0, quesBerSum);
    setBer(15'h0003);
    chk("berSum", 1'h1, quesBerSum);
    rc(`QSG_QUES_COND, 16'h1000, "quesCond");
    rc(`QSG_BER_EVENT, 16'h0006, "berEvt");
    wt(3);
    chk("berSum", 1'h0, quesBerSum);
  endtask
  task automatic t_cal();
    @(posedge sys_clk);
    calZeroFail <= 1'b1;
    wt(6);
    rc(`QSG_CAL_COND, 16'h0001, "calCond");
    wr(`QSG_CAL_ENABLE, 16'h0001);
    wt(3);
    chk("calSum", 1'h1, quesCalSum);
    rc(`QSG_QUES_COND, 16'h0100, "quesCond");
    chk("irq", 1'h0, irq);
    wr(`QSG_IRQ_MASK, 16'h0003);
    wt(3);
    chk("irq", 1'h1, irq);
    rc(`QSG_IRQ_STAT, 16'h0003, "irqStat");
    wr(`QSG_IRQ_STAT, 16'h0003);
    wt(3);
    chk("irq", 1'h0, irq);
    rc(`QSG_CAL_EVENT, 16'h0001, "calEvt");
  endtask
  task automatic t_noclk();
    @(posedge sys_clk);
    berActive <= 1'b1;
    wt(30);
    rc(`QSG_BER_COND, 16'h0007, "berCond");
    @(posedge sys_clk);
    berClkPin <= 1'b1;
    wt(5);
    rc(`QSG_BER_COND, 16'h0006, "berCond");
    @(posedge sys_clk);
    berActive <= 1'b0;
  endtask
  task automatic t_preset();
    wr(`QSG_BER_PTR, 16'h0000);
    wr(`QSG_QUEUE_EN, 32'h0000_0005);
    rc(`QSG_QUEUE_EN, 32'h0000_0005, "queueEn");
    wr(`QSG_PRESET, 16'h0000);
    rc(`QSG_BER_PTR, 16'hFFFF, "berPtr");
    rc(`QSG_BER_NTR, 16'h0000, "berNtr");
    rc(`QSG_BER_ENABLE, 16'h0000, "berEn");
    rc(`QSG_CAL_ENABLE, 16'h0000, "calEn");
    rc(`QSG_QUEUE_EN, 16'h0000, "queueEn");
    rc(`QSG_IRQ_MASK, 32'h0000_0003, "irqMask");
  endtask
  initial begin
    wt(12);
    resetn <= 1'b1;
    t_reset();
    t_edges();
    t_sum();
    t_cal();
    t_noclk();
    t_preset();
    tally_and_finish();
  end
endmodule
`default_nettype wire
